// File: hw/otp_user_regs_defs.vh
// constants for the user OTP configuration and health flag register bank
// assumes a 32-bit AXI4-Lite slave with one aligned word per register index
`ifndef OTP_USER_REGS_DEFS_VH
`define OTP_USER_REGS_DEFS_VH

// register indices; byte address is four times the index
`define IDX_CFG_A 8'h09
`define IDX_CFG_B 8'h0A
`define IDX_CFG_C 8'h0B
`define IDX_HEALTH 8'h0C
`define IDX_MAKER 8'h0D
`define IDX_LOCK 8'h10

// user_config_word_a fields
`define A_EXT_BIT 7
`define A_FREE_RUNNING_TX_ENABLE_BIT 6
`define A_DIR_HI 5
`define A_DIR_LO 4
`define A_REV_HI 3
`define A_REV_LO 0
// user_config_word_b fields
`define B_MONTH_HI 7
`define B_MONTH_LO 4
`define B_YEAR_HI 3
`define B_YEAR_LO 0
// user_config_word_c fields
`define C_SPARE_HI 7
`define C_SPARE_LO 5
`define C_DAY_HI 4
`define C_DAY_LO 0
// lock register fields
`define L_LOCK_BIT 7
`define L_CODE_HI 2
`define L_CODE_LO 0

`define OTP_RESET 8'h00
`define YEAR_BASE 7'h09
`define MONTH_LAST 4'hC
`define CRC_SEED 3'h7
`define SLOT_WIDTH 10
`define EXT_WIDTH 24
`define USER_LOW_WIDTH 31
`define USER_CODE_BITS 63
`define FACTORY_BITS 40

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: hw/otp_user_regs.v
// user OTP configuration words, maker code, lock/check word and health flags
// assumes shadow copies of the OTP fuses and status sources share CLK_IN
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "otp_user_regs_defs.vh"

module otp_user_regs #(
	parameter ADDR_W = 12,
	parameter FACTORY_W = `FACTORY_BITS
) (
	input wire CLK_IN,
	input wire RESETN_IN,
	// AXI4-Lite slave
	input wire [ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output wire S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output wire S_AXI_WREADY_OUT,
	output wire [1:0] S_AXI_BRESP_OUT,
	output wire S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	input wire [ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output wire S_AXI_ARREADY_OUT,
	output wire [31:0] S_AXI_RDATA_OUT,
	output wire [1:0] S_AXI_RRESP_OUT,
	output wire S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// status sources, same clock domain
	input wire TEST_MODE_ACTIVE_IN,
	input wire OC_DONE_IN,
	input wire OFFSET_LIMIT_IN,
	// other user OTP shadow bits (0x05 bits 6:0, 0x06..0x08)
	input wire [`USER_LOW_WIDTH-1:0] USER_LOW_ARRAY_IN,
	// factory OTP shadow
	input wire [FACTORY_W-1:0] FACTORY_ARRAY_IN,
	input wire FACTORY_LOCK_IN,
	input wire [2:0] FACTORY_CRC_IN,
	// slot field and extended phase 2 content from elsewhere
	input wire [`SLOT_WIDTH-1:0] SLOT_DELAY_FIELD_IN,
	input wire [`EXT_WIDTH-1:0] EXT_FIELDS_IN,
	// phase 2 payload and mode outputs
	output wire [`EXT_WIDTH-1:0] EXT_FIELDS_OUT,
	output wire PHASE2_EXTENSION_ENABLE_OUT,
	output wire FREE_RUNNING_TX_ENABLE_OUT,
	output wire DEFAULT_SLOT_SELECT_OUT,
	output wire [3:0] DIRECTION_NIBBLE_OUT,
	output wire [3:0] REVISION_OUT,
	output wire [6:0] CODED_YEAR_OUT,
	output wire [3:0] CODED_MONTH_OUT,
	output wire [4:0] CODED_DAY_OUT,
	output wire [7:0] MAKER_CODE_OUT,
	output wire [7:0] HEALTH_FLAGS_OUT
);

////////////////////////////////////////////////////////////////////////////////
// reset synchroniser

reg rst_meta_r;
reg rst_sync_r;
wire rst_n;

always @(posedge CLK_IN or negedge RESETN_IN) begin
	if (!RESETN_IN) begin
		rst_meta_r <= 1'b0;
		rst_sync_r <= 1'b0;
	end else begin
		rst_meta_r <= 1'b1;
		rst_sync_r <= rst_meta_r;
	end
end

assign rst_n = rst_sync_r;

////////////////////////////////////////////////////////////////////////////////
// serial 3-bit CRC, LSB first, lower index first

function [2:0] crc_user;
	input [`USER_CODE_BITS-1:0] bits;
	integer i;
	reg [2:0] c;
	reg fb;
	begin
		c = `CRC_SEED;
		for (i = 0; i < `USER_CODE_BITS; i = i + 1) begin
			fb = bits[i] ^ c[2];
			c = {c[1], c[0] ^ fb, fb};
		end
		crc_user = c;
	end
endfunction

function [2:0] crc_factory;
	input [FACTORY_W-1:0] bits;
	integer i;
	reg [2:0] c;
	reg fb;
	begin
		c = `CRC_SEED;
		for (i = 0; i < FACTORY_W; i = i + 1) begin
			fb = bits[i] ^ c[2];
			c = {c[1], c[0] ^ fb, fb};
		end
		crc_factory = c;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// OTP shadow registers

reg [7:0] cfg_a_r;
reg [7:0] cfg_b_r;
reg [7:0] cfg_c_r;
reg [7:0] maker_r;
reg [7:0] lock_r;
wire user_locked;

assign user_locked = lock_r[`L_LOCK_BIT];

////////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order

reg aw_full_r;
reg w_full_r;
reg [7:0] aw_idx_r;
reg aw_ok_r;
reg [31:0] w_data_r;
reg w_lane0_r;
reg bvalid_r;
reg [1:0] bresp_r;
wire aw_take;
wire w_take;
wire wr_fire;
wire aw_in_range;

assign S_AXI_AWREADY_OUT = !aw_full_r && !bvalid_r;
assign S_AXI_WREADY_OUT = !w_full_r && !bvalid_r;
assign aw_take = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
assign w_take = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
assign aw_in_range = (S_AXI_AWADDR_IN >> 10) == 0;
assign S_AXI_BVALID_OUT = bvalid_r;
assign S_AXI_BRESP_OUT = bresp_r;

// a writable target that takes the write; locked words ignore it
reg wr_hit;
reg [1:0] wr_resp;

always @* begin
	wr_hit = 1'b0;
	wr_resp = `RESP_OKAY;
	if (!aw_ok_r) begin
		wr_resp = `RESP_SLVERR;
	end else if (aw_idx_r == `IDX_CFG_A || aw_idx_r == `IDX_CFG_B) begin
		wr_hit = 1'b1;
	end else if (aw_idx_r == `IDX_CFG_C || aw_idx_r == `IDX_MAKER) begin
		wr_hit = 1'b1;
	end else if (aw_idx_r == `IDX_LOCK) begin
		wr_hit = 1'b1;
	end else begin
		wr_resp = `RESP_SLVERR; // read-only health word and unmapped
	end
end

always @(posedge CLK_IN or negedge rst_n) begin
	if (!rst_n) begin
		aw_full_r <= 1'b0;
		w_full_r <= 1'b0;
		aw_idx_r <= 8'h00;
		aw_ok_r <= 1'b0;
		w_data_r <= 32'h0000_0000;
		w_lane0_r <= 1'b0;
		bvalid_r <= 1'b0;
		bresp_r <= `RESP_OKAY;
	end else begin
		if (aw_take) begin
			aw_full_r <= 1'b1;
			aw_idx_r <= S_AXI_AWADDR_IN[9:2];
			aw_ok_r <= aw_in_range;
		end
		if (w_take) begin
			w_full_r <= 1'b1;
			w_data_r <= S_AXI_WDATA_IN;
			w_lane0_r <= S_AXI_WSTRB_IN[0];
		end
		if (wr_fire) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b1;
			bresp_r <= wr_resp;
		end else if (bvalid_r && S_AXI_BREADY_IN) begin
			bvalid_r <= 1'b0;
		end
	end
end

// fuse semantics: a bit once blown stays set; all words freeze at lock
wire wr_do;

assign wr_do = wr_fire && wr_hit && w_lane0_r && !user_locked;

always @(posedge CLK_IN or negedge rst_n) begin
	if (!rst_n) begin
		cfg_a_r <= `OTP_RESET;
		cfg_b_r <= `OTP_RESET;
		cfg_c_r <= `OTP_RESET;
		maker_r <= `OTP_RESET;
		lock_r <= `OTP_RESET;
	end else if (wr_do) begin
		if (aw_idx_r == `IDX_CFG_A) begin
			cfg_a_r <= cfg_a_r | w_data_r[7:0];
		end else if (aw_idx_r == `IDX_CFG_B) begin
			cfg_b_r <= cfg_b_r | w_data_r[7:0];
		end else if (aw_idx_r == `IDX_CFG_C) begin
			cfg_c_r <= cfg_c_r | w_data_r[7:0];
		end else if (aw_idx_r == `IDX_MAKER) begin
			maker_r <= maker_r | w_data_r[7:0];
		end else begin
			lock_r <= lock_r | w_data_r[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// integrity checks, latched low until reset

reg user_ok_r;
reg factory_ok_r;
wire [`USER_CODE_BITS-1:0] user_bits;
wire user_mismatch;
wire factory_fault;

// lower offsets first; the lock bit is left out
assign user_bits = {maker_r, cfg_c_r, cfg_b_r, cfg_a_r, USER_LOW_ARRAY_IN};
assign user_mismatch = user_locked &&
	(crc_user(user_bits) != lock_r[`L_CODE_HI:`L_CODE_LO]);
assign factory_fault = FACTORY_LOCK_IN &&
	(crc_factory(FACTORY_ARRAY_IN) != FACTORY_CRC_IN);

always @(posedge CLK_IN or negedge rst_n) begin
	if (!rst_n) begin
		user_ok_r <= 1'b1;
		factory_ok_r <= 1'b1;
	end else begin
		if (user_mismatch) begin
			user_ok_r <= 1'b0;
		end
		if (factory_fault) begin
			factory_ok_r <= 1'b0;
		end
	end
end

// live view of the other flags, sampled as they stand
wire [7:0] health;

assign health = {1'b0, !TEST_MODE_ACTIVE_IN, 1'b0, user_ok_r, OC_DONE_IN,
	factory_ok_r, !OFFSET_LIMIT_IN, 1'b1};

////////////////////////////////////////////////////////////////////////////////
// read channel; reads change no state

reg rvalid_r;
reg [31:0] rdata_r;
reg [1:0] rresp_r;
reg [7:0] rd_byte;
reg [1:0] rd_resp;
wire [7:0] rd_idx;

assign S_AXI_ARREADY_OUT = !rvalid_r;
assign S_AXI_RVALID_OUT = rvalid_r;
assign S_AXI_RDATA_OUT = rdata_r;
assign S_AXI_RRESP_OUT = rresp_r;
assign rd_idx = S_AXI_ARADDR_IN[9:2];

always @* begin
	rd_byte = 8'h00;
	rd_resp = `RESP_OKAY;
	if ((S_AXI_ARADDR_IN >> 10) != 0) begin
		rd_resp = `RESP_SLVERR;
	end else if (rd_idx == `IDX_CFG_A) begin
		rd_byte = cfg_a_r;
	end else if (rd_idx == `IDX_CFG_B) begin
		rd_byte = cfg_b_r;
	end else if (rd_idx == `IDX_CFG_C) begin
		rd_byte = cfg_c_r;
	end else if (rd_idx == `IDX_HEALTH) begin
		rd_byte = health;
	end else if (rd_idx == `IDX_MAKER) begin
		rd_byte = maker_r;
	end else if (rd_idx == `IDX_LOCK) begin
		rd_byte = lock_r;
	end else begin
		rd_resp = `RESP_SLVERR;
	end
end

always @(posedge CLK_IN or negedge rst_n) begin
	if (!rst_n) begin
		rvalid_r <= 1'b0;
		rdata_r <= 32'h0000_0000;
		rresp_r <= `RESP_OKAY;
	end else if (S_AXI_ARVALID_IN && !rvalid_r) begin
		rvalid_r <= 1'b1;
		rdata_r <= {24'h00_0000, rd_byte};
		rresp_r <= rd_resp;
	end else if (rvalid_r && S_AXI_RREADY_IN) begin
		rvalid_r <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// phase 2 payload and transmission mode; date fields steer nothing here

reg [`EXT_WIDTH-1:0] ext_r;
reg ext_en_r;
reg free_running_tx_enable_r;
reg dflt_slot_r;
reg [3:0] dir_r;
reg [3:0] rev_r;
reg [6:0] year_r;
reg [3:0] month_r;
reg [4:0] day_r;
reg [7:0] maker_out_r;
reg [7:0] health_out_r;
wire [3:0] month_raw;

assign month_raw = cfg_b_r[`B_MONTH_HI:`B_MONTH_LO];

always @(posedge CLK_IN or negedge rst_n) begin
	if (!rst_n) begin
		ext_r <= 24'h00_0000;
		ext_en_r <= 1'b0;
		free_running_tx_enable_r <= 1'b0;
		dflt_slot_r <= 1'b0;
		dir_r <= 4'h0;
		rev_r <= 4'h0;
		year_r <= 7'h00;
		month_r <= 4'h0;
		day_r <= 5'h00;
		maker_out_r <= 8'h00;
		health_out_r <= 8'h00;
	end else begin
		ext_en_r <= cfg_a_r[`A_EXT_BIT];
		ext_r <= cfg_a_r[`A_EXT_BIT] ? EXT_FIELDS_IN : 24'h00_0000;
		free_running_tx_enable_r <= cfg_a_r[`A_FREE_RUNNING_TX_ENABLE_BIT];
		dflt_slot_r <= (SLOT_DELAY_FIELD_IN == 0) && !cfg_a_r[`A_FREE_RUNNING_TX_ENABLE_BIT];
		dir_r <= {cfg_a_r[`A_DIR_HI:`A_DIR_LO], 2'b00};
		rev_r <= cfg_a_r[`A_REV_HI:`A_REV_LO];
		year_r <= {3'b000, cfg_b_r[`B_YEAR_HI:`B_YEAR_LO]} + `YEAR_BASE;
		month_r <= (month_raw > `MONTH_LAST) ? 4'h0 : month_raw;
		day_r <= cfg_c_r[`C_DAY_HI:`C_DAY_LO];
		maker_out_r <= maker_r;
		health_out_r <= health;
	end
end

assign EXT_FIELDS_OUT = ext_r;
assign PHASE2_EXTENSION_ENABLE_OUT = ext_en_r;
assign FREE_RUNNING_TX_ENABLE_OUT = free_running_tx_enable_r;
assign DEFAULT_SLOT_SELECT_OUT = dflt_slot_r;
assign DIRECTION_NIBBLE_OUT = dir_r;
assign REVISION_OUT = rev_r;
assign CODED_YEAR_OUT = year_r;
assign CODED_MONTH_OUT = month_r;
assign CODED_DAY_OUT = day_r;
assign MAKER_CODE_OUT = maker_out_r;
assign HEALTH_FLAGS_OUT = health_out_r;

endmodule

// File: bench/otp_user_regs_sva.sv
// checker for the user otp register bank and its health flags
// assumes binding into otp_user_regs; outputs go live 3 edges after reset release
`timescale 1ns/1ns
`include "otp_user_regs_defs.vh"
module otp_user_regs_sva (
	input wire CLK_IN,
	input wire RESETN_IN,
	input wire S_AXI_ARVALID_IN,
	input wire S_AXI_RVALID_OUT,
	input wire [31:0] S_AXI_RDATA_OUT,
	input wire S_AXI_BVALID_OUT,
	input wire TEST_MODE_ACTIVE_IN,
	input wire OC_DONE_IN,
	input wire OFFSET_LIMIT_IN,
	input wire [`SLOT_WIDTH-1:0] SLOT_DELAY_FIELD_IN,
	input wire FREE_RUNNING_TX_ENABLE_OUT,
	input wire DEFAULT_SLOT_SELECT_OUT,
	input wire [3:0] DIRECTION_NIBBLE_OUT,
	input wire [7:0] HEALTH_FLAGS_OUT
);
	// reset copy lags two edges, so hold off until outputs are live
	reg [2:0] up_cnt_r;
	wire up = (up_cnt_r == 3'h4);
	always @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			up_cnt_r <= 3'h0;
		else if (!up)
			up_cnt_r <= up_cnt_r + 3'h1;
	end
	default clocking dc @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	////////////////////////////////////////
	AST_FIXED_BITS: assert property (up |-> !HEALTH_FLAGS_OUT[7] && !HEALTH_FLAGS_OUT[5] && HEALTH_FLAGS_OUT[0])
		else $error("fixed bits wrong");
	AST_TEST_FLAG: assert property (up |-> HEALTH_FLAGS_OUT[6] == !$past(TEST_MODE_ACTIVE_IN))
		else $error("test flag wrong");
	AST_OC_FLAG: assert property (up |-> HEALTH_FLAGS_OUT[3] == $past(OC_DONE_IN))
		else $error("offset cancel flag wrong");
	AST_OFFSET_FLAG: assert property (up |-> HEALTH_FLAGS_OUT[1] != $past(OFFSET_LIMIT_IN))
		else $error("offset flag wrong");
	AST_USER_STICKY: assert property (up && !HEALTH_FLAGS_OUT[4] |=> !HEALTH_FLAGS_OUT[4])
		else $error("user flag recovered");
	AST_FACT_STICKY: assert property (up && !HEALTH_FLAGS_OUT[2] |=> !HEALTH_FLAGS_OUT[2])
		else $error("factory flag recovered");
	AST_DEFAULT_SLOT: assert property (up |-> DEFAULT_SLOT_SELECT_OUT ==
		($past(SLOT_DELAY_FIELD_IN) == '0 && !FREE_RUNNING_TX_ENABLE_OUT))
		else $error("default slot wrong");
	AST_DIR_LOW: assert property (up |-> DIRECTION_NIBBLE_OUT[1:0] == 2'h0)
		else $error("direction nibble wrong");
	AST_READ_TURN: assert property (up && S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	AST_RDATA_UPPER: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h0)
		else $error("read upper bits set");
	COV_WRITE: cover property (S_AXI_BVALID_OUT);
	COV_USER_FAIL: cover property (up && $fell(HEALTH_FLAGS_OUT[4]));
	COV_FACT_FAIL: cover property (up && $fell(HEALTH_FLAGS_OUT[2]));
endmodule

bind otp_user_regs otp_user_regs_sva u_otp_user_regs_sva (.CLK_IN, .RESETN_IN,
	.S_AXI_ARVALID_IN, .S_AXI_RVALID_OUT, .S_AXI_RDATA_OUT, .S_AXI_BVALID_OUT,
	.TEST_MODE_ACTIVE_IN, .OC_DONE_IN, .OFFSET_LIMIT_IN, .SLOT_DELAY_FIELD_IN,
	.FREE_RUNNING_TX_ENABLE_OUT, .DEFAULT_SLOT_SELECT_OUT, .DIRECTION_NIBBLE_OUT,
	.HEALTH_FLAGS_OUT);

// File: bench/ecu_rx_model.sv
// receiver-side model collecting the phase 2 identification payload
// assumes 10-bit response length and payload levels on the local clock
`timescale 1ns/1ns
module ecu_rx_model (
	input wire clk_in,
	input wire [3:0] dir_in,
	input wire [3:0] rev_in,
	input wire [6:0] year_in,
	input wire [3:0] month_in,
	input wire [4:0] day_in,
	input wire [7:0] maker_in,
	output reg [31:0] frame_out
);
	always @(posedge clk_in) begin
		frame_out <= {dir_in, maker_in, day_in, month_in, year_in, rev_in};
	end
endmodule

// File: bench/otp_user_regs_tb.sv
// self-checking bench for the user otp register bank
// assumes the checker is bound in and the receiver model watches the payload
`timescale 1ns/1ns
`include "otp_user_regs_defs.vh"
module otp_user_regs_tb;
	reg clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
	reg rready = 1'b0, test_mode = 1'b0, oc_done = 1'b1, off_lim = 1'b0, f_lock = 1'b0;
	reg [11:0] awaddr = 12'h0, araddr = 12'h0;
	reg [31:0] wdata = 32'h0;
	reg [30:0] user_low = 31'h1234_5678;
	reg [39:0] factory = 40'h12_3456_789A;
	reg [2:0] f_crc = 3'h0;
	reg [9:0] slot = 10'h0;
	reg [23:0] ext_in = 24'hA5_C3F0;
	wire awrdy, wrdy, bvalid, arrdy, rvalid, p2_ext, free_tx, dflt;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, frame;
	wire [23:0] ext_out;
	wire [3:0] dir_nib, rev, month;
	wire [6:0] year;
	wire [4:0] day;
	wire [7:0] maker, health;
	integer failures = 0, checks_done = 0, i;

	otp_user_regs u_otp_user_regs (.CLK_IN(clk), .RESETN_IN(rst_n),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .TEST_MODE_ACTIVE_IN(test_mode),
		.OC_DONE_IN(oc_done), .OFFSET_LIMIT_IN(off_lim), .USER_LOW_ARRAY_IN(user_low),
		.FACTORY_ARRAY_IN(factory), .FACTORY_LOCK_IN(f_lock), .FACTORY_CRC_IN(f_crc),
		.SLOT_DELAY_FIELD_IN(slot), .EXT_FIELDS_IN(ext_in), .EXT_FIELDS_OUT(ext_out),
		.PHASE2_EXTENSION_ENABLE_OUT(p2_ext), .FREE_RUNNING_TX_ENABLE_OUT(free_tx),
		.DEFAULT_SLOT_SELECT_OUT(dflt), .DIRECTION_NIBBLE_OUT(dir_nib), .REVISION_OUT(rev),
		.CODED_YEAR_OUT(year), .CODED_MONTH_OUT(month), .CODED_DAY_OUT(day),
		.MAKER_CODE_OUT(maker), .HEALTH_FLAGS_OUT(health));
	ecu_rx_model u_ecu_rx_model (.clk_in(clk), .dir_in(dir_nib), .rev_in(rev),
		.year_in(year), .month_in(month), .day_in(day), .maker_in(maker), .frame_out(frame));
	////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	function [11:0] ba(input [7:0] idx);
		ba = {2'h0, idx, 2'h0};
	endfunction
	function [2:0] crc3(input [63:0] v, input integer n);
		reg [2:0] c;
		reg fb;
		integer k;
		begin
			c = `CRC_SEED;
			for (k = 0; k < n; k = k + 1) begin
				fb = v[k] ^ c[2];
				c = {c[1], c[0] ^ fb, fb};
			end
			crc3 = c;
		end
	endfunction
	task test_done;
		begin
			if (failures == 0 && checks_done > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// readies and answers are sampled at the falling edge, released after the rising one
	task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
		reg aok, wok, bok;
		reg [1:0] r;
		integer n;
		begin
			@(posedge clk);
			awaddr <= ba(idx);
			wdata <= {24'h0, d};
			awv <= 1'b1;
			wv <= 1'b1;
			bready <= 1'b1;
			bok = 1'b0;
			r = 2'bxx;
			for (n = 0; n < 50 && !bok; n = n + 1) begin
				@(negedge clk);
				aok = awv && awrdy;
				wok = wv && wrdy;
				bok = bvalid;
				r = bresp;
				@(posedge clk);
				if (aok) awv <= 1'b0;
				if (wok) wv <= 1'b0;
			end
			bready <= 1'b0;
			// a response that never came shows up in bit 2
			check({29'h0, !bok, r}, {30'h0, er});
		end
	endtask
	task rd(input [7:0] idx, input [7:0] ed, input [1:0] er);
		reg aok, rok;
		reg [33:0] got;
		integer n;
		begin
			@(posedge clk);
			araddr <= ba(idx);
			arv <= 1'b1;
			rready <= 1'b1;
			rok = 1'b0;
			got = 34'bx;
			for (n = 0; n < 50 && !rok; n = n + 1) begin
				@(negedge clk);
				aok = arv && arrdy;
				rok = rvalid;
				got = {rresp, rdata};
				@(posedge clk);
				if (aok) arv <= 1'b0;
			end
			rready <= 1'b0;
			check(got[31:0], {24'h0, ed});
			check({29'h0, !rok, got[33:32]}, {30'h0, er});
		end
	endtask
	task do_reset;
		begin
			rst_n <= 1'b0;
			repeat (16) @(posedge clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	////////////////////////////////////////
	initial begin
		do_reset;
		for (i = 9; i < 14; i = i + 1)
			rd(i[7:0], (i == 12) ? 8'h5F : 8'h00, `RESP_OKAY);
		check({7'h0, ext_out, dflt}, 32'h1);
		check(frame, {21'h0, 7'h09, 4'h0});
		wr(`IDX_CFG_A, 8'hD5, `RESP_OKAY);
		wr(`IDX_CFG_B, 8'hCF, `RESP_OKAY);
		wr(`IDX_CFG_C, 8'hFF, `RESP_OKAY);
		wr(`IDX_MAKER, 8'hA5, `RESP_OKAY);
		rd(`IDX_CFG_C, 8'hFF, `RESP_OKAY);
		check({ext_out, 5'h0, p2_ext, free_tx, dflt}, {ext_in, 8'h6});
		check(frame, {4'h4, 8'hA5, 5'h1F, 4'hC, 7'h18, 4'h5});
		wr(`IDX_CFG_A, 8'h20, `RESP_OKAY);
		rd(`IDX_CFG_A, 8'hF5, `RESP_OKAY);
		check({28'h0, dir_nib}, 32'hC);
		wr(`IDX_HEALTH, 8'h00, `RESP_SLVERR);
		wr(8'h0F, 8'h01, `RESP_SLVERR);
		rd(8'h0F, 8'h00, `RESP_SLVERR);
		test_mode <= 1'b1;
		oc_done <= 1'b0;
		off_lim <= 1'b1;
		rd(`IDX_HEALTH, 8'h15, `RESP_OKAY);
		test_mode <= 1'b0;
		oc_done <= 1'b1;
		off_lim <= 1'b0;
		rd(`IDX_HEALTH, 8'h5F, `RESP_OKAY);
		f_crc <= crc3({24'h0, factory}, 40);
		f_lock <= 1'b1;
		rd(`IDX_HEALTH, 8'h5F, `RESP_OKAY);
		f_crc <= ~crc3({24'h0, factory}, 40);
		rd(`IDX_HEALTH, 8'h5B, `RESP_OKAY);
		f_crc <= crc3({24'h0, factory}, 40);
		wr(`IDX_LOCK, {5'h10, crc3({9'h1A5, 24'hFF_CFF5, user_low}, 63)}, `RESP_OKAY);
		rd(`IDX_HEALTH, 8'h5B, `RESP_OKAY);
		wr(`IDX_CFG_A, 8'h0A, `RESP_OKAY);
		rd(`IDX_CFG_A, 8'hF5, `RESP_OKAY);
		user_low <= 31'h0;
		rd(`IDX_HEALTH, 8'h4B, `RESP_OKAY);
		user_low <= 31'h1234_5678;
		rd(`IDX_HEALTH, 8'h4B, `RESP_OKAY);
		do_reset;
		rd(`IDX_HEALTH, 8'h5F, `RESP_OKAY);
		slot <= 10'h004;
		wr(`IDX_CFG_B, 8'hD0, `RESP_OKAY);
		// coded month settles on the handshake edge; look half a cycle later
		@(negedge clk);
		check({27'h0, month, dflt}, 32'h0);
		test_done;
	end
	// the whole sequence needs under two hundred cycles; the 50000-cycle limit leaves wide margin
	initial begin
		#500000;
		failures = failures + 1;
		test_done;
	end
endmodule
